/* File: hdl/two_wire_slave_tx_status.sv */
// Purpose: Slave transmitter sequencing and status of the two-wire unit
// Assumes: Control and data writes are one-cycle strobes on CLK_I
// Notes: Master bit-rate generation and receiver modes live elsewhere
`timescale 1ns/1ps
`default_nettype none
module two_wire_slave_tx_status
   import two_wire_pkg::*;
(
   input wire logic CLK_I,
   input wire logic NRST_I,
   input wire logic SCL_I,
   output logic SCL_O,
   output logic SCL_OE_O,
   input wire logic SDA_I,
   output logic SDA_O,
   output logic SDA_OE_O,
   input wire logic [ADDR_W-1:0] OWN_ADDR_I,
   input wire logic GENERAL_CALL_ENABLE_I,
   input wire logic ACK_ENABLE_I,
   input wire logic [PRESCALER_W-1:0] PRESCALER_I,
   input wire logic CTRL_WR_I,
   input wire logic CTRL_FLAG_CLEAR_I,
   input wire logic CTRL_START_REQUEST_I,
   input wire logic CTRL_STOP_REQUEST_I,
   input wire logic DATA_WR_I,
   input wire logic [7:0] DATA_I,
   input wire logic ARB_LOST_I,
   output logic [7:0] STATUS_O,
   output logic JOB_DONE_FLAG_O,
   output logic STOP_REQUEST_BIT_O,
   output logic WRITE_COLLISION_O,
   output logic START_ISSUE_O,
   output logic BUS_OWNED_O,
   output logic [7:0] DATA_BYTE_O
);
   typedef struct packed {
      state_t st;
      logic flag;
      logic [7:0] code;
      logic stop_bit;
      logic start_pend;
      logic bus_busy;
      logic bus_owned;
      logic arb;
      logic last;
      logic collision;
      logic [7:0] data;
      logic [7:0] sh;
      logic [3:0] cnt;
      logic sda_low;
      logic scl_low;
      logic start_pulse;
      logic scl_p;
      logic sda_p;
   } regs_t;

   localparam regs_t REGS_RESET = '{
      st: S_IDLE, flag: 1'b0, code: ST_NO_INFO, stop_bit: 1'b0, start_pend: 1'b0,
      bus_busy: 1'b0, bus_owned: 1'b0, arb: 1'b0, last: 1'b0, collision: 1'b0,
      data: DATA_RESET, sh: DATA_RESET, cnt: 4'h0, sda_low: 1'b0, scl_low: 1'b0,
      start_pulse: 1'b0, scl_p: 1'b1, sda_p: 1'b1};

   regs_t r_q;
   regs_t r_d;
   logic [1:0] pins_s;
   logic scl_s;
   logic sda_s;
   logic scl_rise;
   logic scl_fall;
   logic start_seen;
   logic stop_seen;
   logic sw_clear;
   logic addr_hit;

   two_wire_sync #(
      .WIDTH(2)
   ) u_sync (
      .clk_i(CLK_I),
      .nrst_i(NRST_I),
      .d_i({SCL_I, SDA_I}),
      .q_o(pins_s)
   );

   // Bus events from the synchronised pins
   assign scl_s = pins_s[1];
   assign sda_s = pins_s[0];
   assign scl_rise = scl_s & ~r_q.scl_p;
   assign scl_fall = ~scl_s & r_q.scl_p;
   assign start_seen = scl_s & r_q.scl_p & r_q.sda_p & ~sda_s;
   assign stop_seen = scl_s & r_q.scl_p & ~r_q.sda_p & sda_s;
   // Only a write of one clears the flag; hardware never clears it itself
   assign sw_clear = CTRL_WR_I & CTRL_FLAG_CLEAR_I & r_q.flag;
   // Own address with read direction; ack_enable gates all recognition
   assign addr_hit = ACK_ENABLE_I & (r_q.sh[7:1] == OWN_ADDR_I) & r_q.sh[0];

   // Whole next-state computation
   always_comb begin
      r_d = r_q;
      r_d.scl_p = scl_s;
      r_d.sda_p = sda_s;
      r_d.start_pulse = 1'b0;

      // Software control write: the stop request bit is stored as written, except that the bus error recovery write drops it
      if (CTRL_WR_I) begin
         r_d.stop_bit = CTRL_STOP_REQUEST_I;
      end

      // Data writes only land while the flag is set; otherwise a collision
      if (DATA_WR_I) begin
         if (r_q.flag) begin
            r_d.data = DATA_I;
            r_d.collision = 1'b0;
         end else begin
            r_d.collision = 1'b1;
         end
      end

      // Bus busy tracking and ownership; a repeated start keeps ownership
      if (start_seen) begin
         r_d.bus_busy = 1'b1;
      end
      if (stop_seen) begin
         r_d.bus_busy = 1'b0;
         r_d.bus_owned = 1'b0;
      end

      if (ARB_LOST_I) begin
         r_d.arb = 1'b1;
      end

      case (r_q.st)
         S_IDLE, S_IGNORE: begin
            // Not addressed: the data line stays released, master reads ones
            r_d.sda_low = 1'b0;
            r_d.scl_low = 1'b0;
            if (start_seen) begin
               r_d.st = S_ADDR;
               r_d.cnt = 4'h0;
            end else if (stop_seen) begin
               r_d.st = S_IDLE;
               r_d.arb = 1'b0;
            end
         end
         S_ADDR: begin
            if ((start_seen && r_q.cnt != 4'h0) || stop_seen) begin
               r_d.st = S_ERROR;
            end else if (start_seen) begin
               r_d.cnt = 4'h0;
            end else if (scl_rise) begin
               r_d.sh = {r_q.sh[6:0], sda_s};
               r_d.cnt = r_q.cnt + 4'h1;
            end else if (scl_fall && r_q.cnt == BITS_PER_BYTE) begin
               if (addr_hit) begin
                  r_d.st = S_ADDR_ACK;
                  r_d.sda_low = 1'b1;
               end else begin
                  r_d.st = S_IGNORE;
                  r_d.arb = 1'b0;
               end
            end
         end
         S_ADDR_ACK: begin
            if (start_seen || stop_seen) begin
               r_d.st = S_ERROR;
               r_d.sda_low = 1'b0;
            end else if (scl_fall) begin
               // Address acknowledged: report and stretch the clock
               r_d.sda_low = 1'b0;
               r_d.scl_low = 1'b1;
               r_d.flag = 1'b1;
               r_d.code = r_q.arb ? ST_ARB_READ : ST_OWN_READ;
               r_d.arb = 1'b0;
               r_d.st = S_HOLD;
            end
         end
         S_HOLD: begin
            if (sw_clear) begin
               r_d.flag = 1'b0;
               r_d.scl_low = 1'b0;
               if (r_q.code == ST_DATA_NACK || r_q.code == ST_LAST_ACK) begin
                  // Back to unaddressed; recognition follows ack_enable
                  r_d.st = S_IGNORE;
                  r_d.start_pend = CTRL_START_REQUEST_I;
               end else begin
                  // Load the next byte; ack_enable low marks it as last
                  r_d.last = ~ACK_ENABLE_I;
                  r_d.sh = DATA_WR_I ? DATA_I : r_q.data;
                  r_d.sda_low = DATA_WR_I ? ~DATA_I[7] : ~r_q.data[7];
                  r_d.cnt = 4'h0;
                  r_d.st = S_TX;
               end
            end
         end
         S_TX: begin
            if (start_seen || stop_seen) begin
               r_d.st = S_ERROR;
               r_d.sda_low = 1'b0;
            end else if (scl_fall) begin
               r_d.cnt = r_q.cnt + 4'h1;
               r_d.sh = {r_q.sh[6:0], 1'b1};
               if (r_q.cnt == BITS_PER_BYTE - 4'h1) begin
                  r_d.sda_low = 1'b0;
                  r_d.st = S_RX_ACK;
               end else begin
                  r_d.sda_low = ~r_q.sh[6];
               end
            end
         end
         S_RX_ACK: begin
            if (start_seen || stop_seen) begin
               r_d.st = S_ERROR;
            end else if (scl_rise) begin
               r_d.last = r_q.last;
               r_d.cnt = sda_s ? 4'h1 : 4'h0; // Remember NACK
            end else if (scl_fall) begin
               r_d.flag = 1'b1;
               r_d.scl_low = 1'b1;
               r_d.st = S_HOLD;
               if (r_q.cnt == 4'h1) begin
                  r_d.code = ST_DATA_NACK;
               end else if (r_q.last) begin
                  r_d.code = ST_LAST_ACK;
               end else begin
                  r_d.code = ST_DATA_ACK;
               end
            end
         end
         S_ERROR: begin
            // Lines released; only internal state changes here
            r_d.sda_low = 1'b0;
            r_d.scl_low = 1'b0;
            if (!r_q.flag) begin
               r_d.flag = 1'b1;
               r_d.code = ST_BUS_ERROR;
            end else if (sw_clear && CTRL_STOP_REQUEST_I) begin
               // Recovery write: unaddressed, stop request bit dropped
               r_d.flag = 1'b0;
               r_d.stop_bit = 1'b0;
               r_d.st = S_IGNORE;
               r_d.arb = 1'b0;
            end
         end
         default: begin
            r_d = REGS_RESET;
         end
      endcase

      // START request: immediate repeated start if owned, else wait for free bus
      if (r_q.start_pend && (r_q.bus_owned || !r_q.bus_busy)) begin
         r_d.start_pend = 1'b0;
         r_d.start_pulse = 1'b1;
         r_d.bus_owned = 1'b1;
      end
   end

   // Single state register
   always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         r_q <= REGS_RESET;
      end else begin
         r_q <= r_d;
      end
   end

   // Status shows the code only while the flag is set; prescaler in low bits
   always_comb begin
      STATUS_O = {ST_NO_INFO[7:STATUS_LSB], 1'b0, PRESCALER_I};
      if (r_q.flag) begin
         STATUS_O = {r_q.code[7:STATUS_LSB], 1'b0, PRESCALER_I};
      end
   end

   // Open-drain pins: drive low only, enable high while pulling low
   assign SCL_O = 1'b0;
   assign SCL_OE_O = r_q.scl_low;
   assign SDA_O = 1'b0;
   assign SDA_OE_O = r_q.sda_low;
   assign JOB_DONE_FLAG_O = r_q.flag;
   assign STOP_REQUEST_BIT_O = r_q.stop_bit;
   assign WRITE_COLLISION_O = r_q.collision;
   assign START_ISSUE_O = r_q.start_pulse;
   assign BUS_OWNED_O = r_q.bus_owned;
   assign DATA_BYTE_O = r_q.data;
endmodule
`default_nettype wire

/* File: hdl/two_wire_pkg.sv */
// Purpose: Shared constants for the two-wire slave transmitter status block
// Assumes: Status codes are full byte values; the status field is bits 7..3
// Notes: Summary of operation follows
// Summary of operation
// - Own address read acknowledged reports A8, sends
// - Lost arbitration then read-addressed reports B0
// - Acked data byte reports B8, waits
// - NACK after byte reports C0
// - ACK on marked last byte reports C8
// - C0/C8 clear with ack_enable 0: unaddressed, deaf
// - C0/C8 clear with ack_enable 1: listens again
// - Start request at C0/C8 clear issues START when free
// - Codes valid with prescaler bits masked zero
// - Flag clear always reports F8
// - Misplaced START/STOP is bus error 00
// - Bus error sets the job done flag
// - Recovery: unaddressed, stop request bit cleared
// - Recovery releases both lines, no STOP driven
// - Direction change uses REPEATED START
// - Repeated start keeps bus ownership
// - Extra master reads get all ones
// - Status in bits 7..3, prescaler 1..0
package two_wire_pkg;
   localparam logic [7:0] ST_OWN_READ = 8'ha8;
   localparam logic [7:0] ST_ARB_READ = 8'hb0;
   localparam logic [7:0] ST_DATA_ACK = 8'hb8;
   localparam logic [7:0] ST_DATA_NACK = 8'hc0;
   localparam logic [7:0] ST_LAST_ACK = 8'hc8;
   localparam logic [7:0] ST_NO_INFO = 8'hf8;
   localparam logic [7:0] ST_BUS_ERROR = 8'h00;
   localparam int STATUS_LSB = 3;
   localparam int PRESCALER_W = 2;
   localparam int ADDR_W = 7;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [7:0] DATA_RESET = 8'hff;
   localparam int LINK_PERIOD_NS = 320;
   localparam int CLK_PERIOD_NS = 40;
   localparam int LINK_CYCLES = (LINK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Gray coded along idle, address, ack, hold, transmit, data ack
   typedef enum logic [2:0] {
      S_IDLE = 3'h0,
      S_ADDR = 3'h1,
      S_ADDR_ACK = 3'h3,
      S_HOLD = 3'h2,
      S_TX = 3'h6,
      S_RX_ACK = 3'h7,
      S_IGNORE = 3'h5,
      S_ERROR = 3'h4
   } state_t;
endpackage

/* File: hdl/two_wire_sync.sv */
// Purpose: Two-stage synchroniser for the serial clock and data pins
// Assumes: Inputs are asynchronous to CLK_I
// Notes: The first stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module two_wire_sync #(
   parameter int WIDTH = 2
) (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic [WIDTH-1:0] d_i,
   output logic [WIDTH-1:0] q_o
);
   logic [WIDTH-1:0] meta_q;

   // Pins idle high, so reset to high avoids false edges
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         meta_q <= '1;
         q_o <= '1;
      end else begin
         meta_q <= d_i;
         q_o <= meta_q;
      end
   end
endmodule
`default_nettype wire

/* File: testbench/two_wire_slave_tx_status_properties.sv */
// Purpose: Port-level checks of the slave transmitter status block
// Assumes: One clock domain, reset active low
// Notes: Status codes compare on bits 7..3; prescaler rides in 1..0
`timescale 1ns/1ps
`default_nettype none
module two_wire_status_chk
   import two_wire_pkg::*;
(
   input wire logic CLK_I,
   input wire logic NRST_I,
   input wire logic SCL_OE_O,
   input wire logic SDA_OE_O,
   input wire logic [PRESCALER_W-1:0] PRESCALER_I,
   input wire logic CTRL_WR_I,
   input wire logic CTRL_FLAG_CLEAR_I,
   input wire logic CTRL_STOP_REQUEST_I,
   input wire logic [7:0] STATUS_O,
   input wire logic JOB_DONE_FLAG_O,
   input wire logic STOP_REQUEST_BIT_O,
   input wire logic START_ISSUE_O,
   input wire logic BUS_OWNED_O
);
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!NRST_I);
   // A clear of a held job must free the clock at once, or the bus stays stuck
   sequence clear_req;
      CTRL_WR_I && CTRL_FLAG_CLEAR_I && JOB_DONE_FLAG_O && STATUS_O[7:3] != 5'h00;
   endsequence
   sequence released;
      !JOB_DONE_FLAG_O && !SCL_OE_O;
   endsequence
   sequence recover_req;
      CTRL_WR_I && CTRL_FLAG_CLEAR_I && CTRL_STOP_REQUEST_I && JOB_DONE_FLAG_O && STATUS_O[7:3] == 5'h00;
   endsequence
   no_info_code_a: assert property (!JOB_DONE_FLAG_O |-> STATUS_O[7:3] == ST_NO_INFO[7:3])
      else $error("status not idle code while flag low");
   prescaler_field_a: assert property (STATUS_O[2:0] == {1'b0, PRESCALER_I})
      else $error("status low bits wrong");
   stretch_hold_a: assert property (JOB_DONE_FLAG_O && STATUS_O[7:3] != 5'h00 |-> SCL_OE_O)
      else $error("clock not held while flag set");
   error_release_a: assert property (JOB_DONE_FLAG_O && STATUS_O[7:3] == 5'h00 |-> !SCL_OE_O && !SDA_OE_O)
      else $error("lines driven in bus error");
   clear_release_a: assert property (clear_req |=> released)
      else $error("flag clear not taken");
   recovery_done_a: assert property (recover_req |=> !JOB_DONE_FLAG_O && !STOP_REQUEST_BIT_O && !SCL_OE_O)
      else $error("bus error recovery incomplete");
   flag_sticky_a: assert property (JOB_DONE_FLAG_O && !(CTRL_WR_I && CTRL_FLAG_CLEAR_I) |=> JOB_DONE_FLAG_O)
      else $error("flag dropped without clear");
   issue_pulse_a: assert property (START_ISSUE_O |=> !START_ISSUE_O && BUS_OWNED_O)
      else $error("start issue not a single pulse");
endmodule
bind two_wire_slave_tx_status two_wire_status_chk u_chk (.CLK_I(CLK_I), .NRST_I(NRST_I), .SCL_OE_O(SCL_OE_O),
   .SDA_OE_O(SDA_OE_O), .PRESCALER_I(PRESCALER_I), .CTRL_WR_I(CTRL_WR_I), .CTRL_FLAG_CLEAR_I(CTRL_FLAG_CLEAR_I),
   .CTRL_STOP_REQUEST_I(CTRL_STOP_REQUEST_I), .STATUS_O(STATUS_O), .JOB_DONE_FLAG_O(JOB_DONE_FLAG_O),
   .STOP_REQUEST_BIT_O(STOP_REQUEST_BIT_O), .START_ISSUE_O(START_ISSUE_O), .BUS_OWNED_O(BUS_OWNED_O));
`default_nettype wire

/* File: testbench/two_wire_master_model.sv */
// Purpose: Behavioural bus master that reads from the slave
// Assumes: Open-drain lines with pull-ups outside this model
// Notes: Clock stands still high between frames; waits out stretching
`timescale 1ns/1ps
`default_nettype none
module two_wire_master_model (
   input wire logic scl_i,
   input wire logic sda_i,
   output logic scl_low_o,
   output logic sda_low_o
);
   // Both lines released at power up
   initial begin
      scl_low_o = 1'b0;
      sda_low_o = 1'b0;
   end
   // Data set while clock low, sampled mid high; released after the fall
   // Low 160 ns and high 160 ns give a 320 ns bit when nobody stretches
   task automatic bit_x(input logic b, output logic r);
      sda_low_o = !b;
      #120;
      scl_low_o = 1'b0;
      wait (scl_i);
      #80;
      r = sda_i;
      #80;
      scl_low_o = 1'b1;
      #40;
      sda_low_o = 1'b0;
   endtask
   task automatic start_c();
      sda_low_o = 1'b1;
      #160;
      scl_low_o = 1'b1;
   endtask
   task automatic stop_c();
      sda_low_o = 1'b1;
      #160;
      scl_low_o = 1'b0;
      wait (scl_i);
      #160;
      sda_low_o = 1'b0;
      #160;
   endtask
   // Most significant bit first, then the slave's answer
   task automatic tx(input logic [7:0] v, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_x(v[i], r);
      bit_x(1'b1, ack);
   endtask
   task automatic rx(input logic k, output logic [7:0] v);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_x(1'b1, r);
         v[i] = r;
      end
      bit_x(k, r);
   endtask
endmodule
`default_nettype wire

/* File: testbench/testbench.sv */
// Purpose: Self-checking bench for the slave transmitter status block
// Assumes: Master model on open-drain lines with pull-ups
// Notes: Address, bytes and prescaler random from a fixed seed
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import two_wire_pkg::*;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic scl_oe, sda_oe, m_scl, m_sda, gce, ae, cwr, cclr, csta, csto, dwr, arb, flag, stob, wcol, sti, own, r;
   logic [ADDR_W-1:0] addr;
   logic [PRESCALER_W-1:0] ps;
   logic [7:0] din, st, dout, b, d;
   wire scl;
   wire sda;
   int error_cnt = 0;
   int samples_checked = 0;
   int issued = 0;
   // Wired-and with pull-ups
   assign scl = !(scl_oe || m_scl);
   assign sda = !(sda_oe || m_sda);
   always #20 clk = ~clk;
   always @(posedge clk) if (sti === 1'b1) issued++;
   two_wire_slave_tx_status uut (.CLK_I(clk), .NRST_I(nrst), .SCL_I(scl), .SCL_O(), .SCL_OE_O(scl_oe), .SDA_I(sda),
      .SDA_O(), .SDA_OE_O(sda_oe), .OWN_ADDR_I(addr), .GENERAL_CALL_ENABLE_I(gce), .ACK_ENABLE_I(ae),
      .PRESCALER_I(ps), .CTRL_WR_I(cwr), .CTRL_FLAG_CLEAR_I(cclr), .CTRL_START_REQUEST_I(csta),
      .CTRL_STOP_REQUEST_I(csto), .DATA_WR_I(dwr), .DATA_I(din), .ARB_LOST_I(arb), .STATUS_O(st),
      .JOB_DONE_FLAG_O(flag), .STOP_REQUEST_BIT_O(stob), .WRITE_COLLISION_O(wcol), .START_ISSUE_O(sti),
      .BUS_OWNED_O(own), .DATA_BYTE_O(dout));
   two_wire_master_model m (.scl_i(scl), .sda_i(sda), .scl_low_o(m_scl), .sda_low_o(m_sda));
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      samples_checked++;
      if (g !== e) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   // Status as software reads it, prescaler appended
   function automatic logic [7:0] stx(input logic [7:0] c);
      return {c[7:3], 1'b0, ps};
   endfunction
   // Bounded wait for the job done flag
   task automatic wflag();
      for (int i = 0; i < 40 && flag !== 1'b1; i++) @(negedge clk);
      chk("flag", 8'h01, {7'h0, flag});
   endtask
   // Optional data load, then one control write that clears the flag
   task automatic ctl(input logic s, input logic p, input logic a, input logic ld, input logic [7:0] v);
      @(negedge clk);
      dwr = ld;
      din = v;
      @(negedge clk);
      dwr = 1'b0;
      {cwr, cclr, csta, csto, ae} = {2'b11, s, p, a};
      @(negedge clk);
      {cwr, csta, csto} = 3'b000;
      @(negedge clk);
   endtask
   task automatic rd(input logic [7:0] e, input logic k, input logic [7:0] c);
      m.rx(k, d);
      chk("read byte", e, d);
      wflag();
      chk("status", stx(c), st);
   endtask
   task automatic adr(input logic [7:0] c);
      @(negedge clk);
      ps = PRESCALER_W'($urandom);
      gce = 1'($urandom);
      m.start_c();
      m.tx({addr, 1'b1}, r);
      chk("address ack", 8'h00, {7'h0, r});
      wflag();
      chk("status", stx(c), st);
   endtask
   task automatic summarize();
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // Main sequence
   initial begin
      {ae, gce, cwr, cclr, csta, csto, dwr, arb, ps, din} = {1'b1, 9'h0, 8'h00};
      void'($urandom(22939));
      addr = ADDR_W'($urandom);
      repeat (12) @(negedge clk);
      nrst = 1'b1;
      repeat (4) @(negedge clk);
      chk("idle status", stx(ST_NO_INFO), st);
      adr(ST_OWN_READ);
      chk("clock held", 8'h01, {7'h0, scl_oe});
      repeat ($urandom_range(1, 3)) begin
         b = 8'($urandom);
         ctl(1'b0, 1'b0, 1'b1, 1'b1, b);
         chk("data byte", b, dout);
         rd(b, 1'b0, ST_DATA_ACK);
      end
      b = 8'($urandom);
      ctl(1'b0, 1'b0, 1'b0, 1'b1, b);
      rd(b, 1'b0, ST_LAST_ACK);
      ctl(1'b1, 1'b0, 1'b1, 1'b0, 8'h00);
      // A data write while the flag is low must be refused and flagged
      dwr = 1'b1;
      @(negedge clk);
      dwr = 1'b0;
      chk("collision", 8'h01, {7'h0, wcol});
      m.rx(1'b1, d);
      chk("extra read", 8'hff, d);
      chk("issue while busy", 8'h00, 8'(issued));
      m.stop_c();
      for (int i = 0; i < 40 && issued == 0; i++) @(negedge clk);
      chk("issue after stop", 8'h01, 8'(issued));
      @(negedge clk);
      arb = 1'b1;
      @(negedge clk);
      arb = 1'b0;
      adr(ST_ARB_READ);
      chk("owned", 8'h01, {7'h0, own});
      b = 8'($urandom);
      ctl(1'b0, 1'b0, 1'b1, 1'b1, b);
      chk("collision cleared", 8'h00, {7'h0, wcol});
      rd(b, 1'b1, ST_DATA_NACK);
      ctl(1'b0, 1'b0, 1'b0, 1'b0, 8'h00);
      m.stop_c();
      m.start_c();
      m.tx({addr, 1'b1}, r);
      chk("deaf ack", 8'h01, {7'h0, r});
      chk("no info", stx(ST_NO_INFO), st);
      m.stop_c();
      @(negedge clk);
      ae = 1'b1;
      m.start_c();
      m.bit_x(1'b1, r);
      m.bit_x(1'b0, r);
      m.stop_c();
      wflag();
      chk("bus error", stx(ST_BUS_ERROR), st);
      ctl(1'b0, 1'b0, 1'b1, 1'b0, 8'h00);
      chk("refused clear", 8'h01, {7'h0, flag});
      ctl(1'b0, 1'b1, 1'b1, 1'b0, 8'h00);
      chk("recovered", 8'h00, {5'h0, flag, stob, scl_oe | sda_oe});
      adr(ST_OWN_READ);
      summarize();
   end
   // Watchdog well beyond the expected run of about 35 us
   initial begin
      #400000;
      error_cnt++;
      summarize();
   end
endmodule
`default_nettype wire
